// ### include/rsc_pkg.sv
// Package for the reset strap configuration capture block
`default_nettype none
package rsc_pkg;
  // Strap pin positions on the sampled data bus
  localparam int OP_MODE_HI_BIT  = 26;
  localparam int OP_MODE_MID_BIT = 17;
  localparam int OP_MODE_LO_BIT  = 16;
  localparam int PORT_HI_BIT     = 20;
  localparam int PORT_LO_BIT     = 19;
  localparam int DRIVE_BIT       = 21;
  localparam int CLK_HI_BIT      = 23;
  localparam int CLK_LO_BIT      = 22;
  localparam int PIN_HI_BIT      = 25;
  localparam int PIN_LO_BIT      = 24;

  localparam logic [2:0] OP_MODE_MASTER = 3'h7;

  typedef enum logic [1:0] {
    RSC_PORT_32 = 2'h0,
    RSC_PORT_16 = 2'h1,
    RSC_PORT_8  = 2'h2
  } rsc_port_t;

  typedef enum logic [1:0] {
    RSC_CLK_EXT_NO_PLL = 2'h0,
    RSC_CLK_PLL_1TO1   = 2'h1,
    RSC_CLK_PLL_EXTREF = 2'h2,
    RSC_CLK_PLL_XTAL   = 2'h3
  } rsc_clk_t;

  // Chip select enables for the three upper port pins, {cs6, cs5, cs4}
  localparam logic [2:0] CS_NONE  = 3'h0;
  localparam logic [2:0] CS_SIX   = 3'h4;
  localparam logic [2:0] CS_SIX_5 = 3'h6;
  localparam logic [2:0] CS_ALL   = 3'h7;

  typedef struct packed {
    logic [2:0] op_mode;
    logic       mode_reserved;
    rsc_port_t  port;
    logic       drive_full;
    rsc_clk_t   clk;
    logic [2:0] cs_en;
    logic       strapped;
  } rsc_cfg_t;

  localparam rsc_cfg_t CFG_DEFAULT = '{
    op_mode:       OP_MODE_MASTER,
    mode_reserved: 1'b0,
    port:          RSC_PORT_32,
    drive_full:    1'b0,
    clk:           RSC_CLK_PLL_XTAL,
    cs_en:         CS_NONE,
    strapped:      1'b0
  };

  // Register map, byte addresses
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STRAP  = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;
  localparam int          CTRL_FORCE_FULL_BIT = 0;
  localparam int          CFG_VALID_BIT       = 14;

  // Reset-out stretch after reset release
  localparam int RESET_OUT_HOLD_NS = 1000;
  localparam int CLOCK_PERIOD_NS   = 25;
  localparam int RESET_OUT_CYCLES  =
    (RESET_OUT_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SYNC_SETTLE_CYCLES = 3;
endpackage : rsc_pkg
`default_nettype wire

// ### verilog/rsc_strap_capture.sv
// Reset strap configuration capture with APB status and control
//
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module rsc_strap_capture
  import rsc_pkg::*;
#(
  parameter int HOLD_CYCLES = rsc_pkg::RESET_OUT_CYCLES
)
(
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic              STRAP_CONFIG_ENABLE_N,
  input  wire logic [31:0]       DATA_PINS,
  output logic                   RESET_OUT_N,
  output logic                   CONFIG_VALID,
  output logic                   MASTER_MODE,
  output logic                   MODE_RESERVED,
  output rsc_pkg::rsc_port_t     BOOT_PORT_WIDTH,
  output logic                   PAD_DRIVE_FULL,
  output rsc_pkg::rsc_clk_t      CLOCK_MODE,
  output logic [2:0]             CHIP_SELECT_EN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);
  import rsc_pkg::*;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_CAPTURE,
    ST_RUN
  } rsc_state_t;

  // Last hold count before the capture cycle
  localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);

  // Sequencing, synchroniser and captured settings
  rsc_state_t  state_reg;
  rsc_state_t  state_next;
  logic [15:0] hold_cnt_reg;
  logic        en_meta_reg;
  logic        en_sync_reg;
  logic [31:0] pin_meta_reg;
  logic [31:0] pin_sync_reg;
  rsc_cfg_t    cfg_reg;
  logic [31:0] strap_raw_reg;
  logic        valid_reg;
  logic        force_full_reg;
  logic        drive_out_reg;
  logic        rst_out_n_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        setup_phase;
  logic        access_done;
  rsc_cfg_t    cfg_capture;
  logic        master_reg;
  logic [31:0] rd_word;
  logic        rd_error;

  // True when the three mode straps select master operation
  function automatic logic mode_is_master(input logic [2:0] m);
    return (m == OP_MODE_MASTER);
  endfunction : mode_is_master

  // Both 00 and 11 on the width straps mean the full 32-bit boot port
  function automatic rsc_port_t decode_port(input logic [1:0] s);
    rsc_port_t p;
    p = RSC_PORT_32;
    unique case (s)
      2'b00:   p = RSC_PORT_32;
      2'b10:   p = RSC_PORT_8;
      2'b01:   p = RSC_PORT_16;
      2'b11:   p = RSC_PORT_32;
    endcase
    return p;
  endfunction : decode_port

  // Upper port pins are taken over for chip selects from the top down
  function automatic logic [2:0] decode_cs(input logic [1:0] s);
    logic [2:0] cs;
    cs = CS_NONE;
    unique case (s)
      2'b00:   cs = CS_NONE;
      2'b10:   cs = CS_SIX;
      2'b01:   cs = CS_SIX_5;
      2'b11:   cs = CS_ALL;
    endcase
    return cs;
  endfunction : decode_cs

  function automatic rsc_cfg_t decode_straps(input logic [31:0] d);
    rsc_cfg_t c;
    c = CFG_DEFAULT;
    c.op_mode = {d[OP_MODE_HI_BIT], d[OP_MODE_MID_BIT], d[OP_MODE_LO_BIT]};
    c.mode_reserved = !mode_is_master(c.op_mode);
    c.port = decode_port({d[PORT_HI_BIT], d[PORT_LO_BIT]});
    c.drive_full = d[DRIVE_BIT];
    c.clk = rsc_clk_t'({d[CLK_HI_BIT], d[CLK_LO_BIT]});
    c.cs_en = decode_cs({d[PIN_HI_BIT], d[PIN_LO_BIT]});
    c.strapped = 1'b1;
    return c;
  endfunction : decode_straps

  function automatic logic [31:0] cfg_word(input rsc_cfg_t c, input logic v);
    logic [31:0] w;
    w = 32'h0;
    w[$bits(rsc_cfg_t)-1:0] = c;
    w[CFG_VALID_BIT] = v;
    return w;
  endfunction : cfg_word

  // Strap pins are asynchronous to CLOCK
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      en_meta_reg  <= 1'b1;
      en_sync_reg  <= 1'b1;
      pin_meta_reg <= 32'h0;
      pin_sync_reg <= 32'h0;
    end
    else
    begin
      en_meta_reg  <= STRAP_CONFIG_ENABLE_N;
      en_sync_reg  <= en_meta_reg;
      pin_meta_reg <= DATA_PINS;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Async reset cannot take pin levels, so the block stretches its own
  // reset-out after release and samples near the end of that stretch.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HOLD:
        if (hold_cnt_reg >= HOLD_LAST)
          state_next = ST_CAPTURE;
      ST_CAPTURE:
        state_next = ST_RUN;
      ST_RUN:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      state_reg <= ST_HOLD;
    else
      state_reg <= state_next;
  end

  // Counter stops once capture is reached, so it never wraps
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      hold_cnt_reg <= 16'h0;
    else if (state_reg == ST_HOLD)
      hold_cnt_reg <= hold_cnt_reg + 16'h1;
  end

  // Reset-out stays low through capture so the strap latch still drives
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      rst_out_n_reg <= 1'b0;
    else
      rst_out_n_reg <= (state_next == ST_RUN);
  end

  // Straps count only when the enable pin was low; otherwise defaults
  always_comb
  begin
    if (!en_sync_reg)
      cfg_capture = decode_straps(pin_sync_reg);
    else
      cfg_capture = CFG_DEFAULT;
  end

  // Defaults stand from reset; only the capture cycle can change them
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_reg       <= CFG_DEFAULT;
      strap_raw_reg <= 32'h0;
      valid_reg     <= 1'b0;
    end
    else if (state_reg == ST_CAPTURE)
    begin
      strap_raw_reg <= pin_sync_reg;
      valid_reg     <= 1'b1;
      cfg_reg       <= cfg_capture;
    end
  end

  // Master flag gets its own flop so the pin is not a gate output
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      master_reg <= !CFG_DEFAULT.mode_reserved;
    else if (state_reg == ST_CAPTURE)
      master_reg <= mode_is_master(cfg_capture.op_mode);
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      drive_out_reg <= 1'b0;
    else
      drive_out_reg <= cfg_reg.drive_full | force_full_reg;
  end

  // APB slave: answer prepared in the setup cycle, so the access phase
  // completes at its first edge; PREADY stands for that one cycle only
  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & pready_reg;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      pready_reg <= 1'b0;
    else
      pready_reg <= setup_phase;
  end

  // Read mux; writes return zero, unmapped offsets flag an error
  always_comb
  begin
    rd_word  = 32'h0;
    rd_error = 1'b0;
    unique case (PADDR)
      ADDR_CONFIG:
        rd_word = cfg_word(cfg_reg, valid_reg);
      ADDR_STRAP:
        rd_word = strap_raw_reg;
      ADDR_CTRL:
        rd_word[CTRL_FORCE_FULL_BIT] = force_full_reg;
      default:
        rd_error = 1'b1;
    endcase
    if (PWRITE)
      rd_word = 32'h0;
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_reg  <= rd_word;
      pslverr_reg <= rd_error;
    end
  end

  // Software may only raise drive, never undo captured full drive
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      force_full_reg <= 1'b0;
    else if (access_done && PWRITE && PADDR == ADDR_CTRL)
      force_full_reg <= PWDATA[CTRL_FORCE_FULL_BIT];
  end

  assign RESET_OUT_N     = rst_out_n_reg;
  assign CONFIG_VALID    = valid_reg;
  // Every output pin is a flop; no gate sits between register and pin
  assign MASTER_MODE     = master_reg;
  assign MODE_RESERVED   = cfg_reg.mode_reserved;
  assign BOOT_PORT_WIDTH = cfg_reg.port;
  assign PAD_DRIVE_FULL  = drive_out_reg;
  assign CLOCK_MODE      = cfg_reg.clk;
  assign CHIP_SELECT_EN  = cfg_reg.cs_en;
  assign PRDATA          = prdata_reg;
  assign PREADY          = pready_reg;
  assign PSLVERR         = pslverr_reg;

endmodule : rsc_strap_capture
`default_nettype wire

// ### testbench/rsc_strap_capture_assertions.sv
// Concurrent checks on the strap capture outputs
`default_nettype none
module rsc_strap_capture_assertions
  import rsc_pkg::*;
#(
  parameter int HOLD_CYCLES = 4
)
(
  input wire logic               CLOCK,
  input wire logic               NRST,
  input wire logic               STRAP_CONFIG_ENABLE_N,
  input wire logic [31:0]        DATA_PINS,
  input wire logic               RESET_OUT_N,
  input wire logic               CONFIG_VALID,
  input wire logic               MASTER_MODE,
  input wire logic               MODE_RESERVED,
  input wire rsc_pkg::rsc_port_t BOOT_PORT_WIDTH,
  input wire rsc_pkg::rsc_clk_t  CLOCK_MODE,
  input wire logic [2:0]         CHIP_SELECT_EN,
  input wire logic               PREADY,
  input wire logic               PSLVERR
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] wait_cnt;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Edges spent with reset-out low since the last reset release
  always_ff @(posedge CLOCK or negedge NRST)
    if (!NRST)
      wait_cnt <= 8'h0;
    else if (!RESET_OUT_N)
      wait_cnt <= wait_cnt + 8'h1;
  // Pins reach the capture flops through two sync stages
  sequence s_cap;
    $rose(CONFIG_VALID) && !$past(STRAP_CONFIG_ENABLE_N, 3);
  endsequence
  property p_out_valid;
    RESET_OUT_N == CONFIG_VALID;
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("reset-out differs from valid");
  property p_cap_time;
    $rose(RESET_OUT_N) |-> wait_cnt == HOLD_CYCLES + 1;
  endproperty
  a_cap_time: assert property (p_cap_time) else $error("capture at wrong edge");
  property p_hold;
    CONFIG_VALID |=> $stable({MASTER_MODE, BOOT_PORT_WIDTH, CLOCK_MODE, CHIP_SELECT_EN});
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed after capture");
  property p_excl;
    CONFIG_VALID |-> MASTER_MODE != MODE_RESERVED;
  endproperty
  a_excl: assert property (p_excl) else $error("mode flags inconsistent");
  property p_default;
    $rose(CONFIG_VALID) && $past(STRAP_CONFIG_ENABLE_N, 3) |-> MASTER_MODE &&
      BOOT_PORT_WIDTH == RSC_PORT_32 && CLOCK_MODE == RSC_CLK_PLL_XTAL && !CHIP_SELECT_EN;
  endproperty
  a_default: assert property (p_default) else $error("defaults not applied");
  property p_mode;
    s_cap |-> MASTER_MODE == &{$past(DATA_PINS[26], 3), $past(DATA_PINS[17:16], 3)};
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_port;
    s_cap |-> BOOT_PORT_WIDTH ==
      (&$past(DATA_PINS[20:19], 3) ? 2'h0 : $past(DATA_PINS[20:19], 3));
  endproperty
  a_port: assert property (p_port) else $error("port width decode wrong");
  property p_clk;
    s_cap |-> CLOCK_MODE == $past(DATA_PINS[23:22], 3);
  endproperty
  a_clk: assert property (p_clk) else $error("clock mode decode wrong");
  c_strap: cover property (s_cap);
  c_default: cover property ($rose(CONFIG_VALID) && $past(STRAP_CONFIG_ENABLE_N, 3));
  c_slverr: cover property (PREADY && PSLVERR);
endmodule : rsc_strap_capture_assertions
`default_nettype wire

// ### testbench/rsc_strap_latch.sv
// Board latch model that presents strap levels while reset-out is low
`default_nettype none
module rsc_strap_latch
(
  input  wire logic        clock,
  input  wire logic        reset_out_n,
  input  wire logic [31:0] word,
  input  wire logic        en_n,
  output logic [31:0]      pins,
  output logic             cfg_en_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog = 1'b0;
  always @(posedge clock) tog <= ~tog;
  // Released bus inverts the strap word on alternate cycles, so strap levels reappear every other cycle
  assign pins = reset_out_n ? word ^ {32{~tog}} : word;
  // Pull-up keeps the enable inactive once the latch lets go
  assign cfg_en_n = reset_out_n ? 1'b1 : en_n;
endmodule : rsc_strap_latch
`default_nettype wire

// ### testbench/rsc_strap_capture_tb_top.sv
// Self-checking testbench for the strap capture block
`default_nettype none
module rsc_strap_capture_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rsc_pkg::*;
  localparam int HOLD = 4;
  logic        CLOCK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        en_sel = 1'b1, STRAP_CONFIG_ENABLE_N, RESET_OUT_N, CONFIG_VALID, err;
  logic        MASTER_MODE, MODE_RESERVED, PAD_DRIVE_FULL, PREADY, PSLVERR;
  logic [31:0] word = 32'h0, PWDATA = 32'h0, DATA_PINS, PRDATA, rd;
  logic [11:0] PADDR = 12'h0;
  logic [2:0]  CHIP_SELECT_EN;
  rsc_port_t   BOOT_PORT_WIDTH;
  rsc_clk_t    CLOCK_MODE;
  int          err_count = 0, compares = 0;
  always #12.5 CLOCK = ~CLOCK;
  rsc_strap_latch u_latch (.clock(CLOCK), .reset_out_n(RESET_OUT_N), .word(word),
    .en_n(en_sel), .pins(DATA_PINS), .cfg_en_n(STRAP_CONFIG_ENABLE_N));
  rsc_strap_capture #(.HOLD_CYCLES(HOLD)) dut (.CLOCK, .NRST, .STRAP_CONFIG_ENABLE_N,
    .DATA_PINS, .RESET_OUT_N, .CONFIG_VALID, .MASTER_MODE, .MODE_RESERVED,
    .BOOT_PORT_WIDTH, .PAD_DRIVE_FULL, .CLOCK_MODE, .CHIP_SELECT_EN, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  function automatic logic [9:0] exp_cfg(logic [31:0] w, logic e);
    logic       m;
    logic [1:0] p;
    m = w[26] & w[17] & w[16];
    p = (w[20:19] == 2'h3) ? 2'h0 : w[20:19];
    if (e)
      return 10'h218;
    return {m, ~m, p, w[21], w[23:22], w[25] | w[24], w[24], w[25] & w[24]};
  endfunction : exp_cfg
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      err_count++;
      $display("mismatch at %0t: no ready", $time);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic run(logic [31:0] w, logic e);
    logic [9:0] x;
    int         n = 0;
    x = exp_cfg(w, e);
    @(posedge CLOCK);
    NRST <= 1'b0;
    word <= w;
    en_sel <= e;
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    while (CONFIG_VALID !== 1'b1 && n++ < 60) @(posedge CLOCK);
    repeat (3) @(negedge CLOCK);
    chk(CONFIG_VALID, 1'b1);
    chk({MASTER_MODE, MODE_RESERVED, BOOT_PORT_WIDTH, PAD_DRIVE_FULL, CLOCK_MODE,
      CHIP_SELECT_EN}, x);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk({rd[14], rd[0]}, {1'b1, ~e});
    apb(1'b0, ADDR_STRAP, 32'h0);
    chk(rd, w);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(negedge CLOCK);
    chk(PAD_DRIVE_FULL, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(negedge CLOCK);
    chk({MASTER_MODE, MODE_RESERVED, BOOT_PORT_WIDTH, PAD_DRIVE_FULL, CLOCK_MODE,
      CHIP_SELECT_EN}, x);
    $display("test done: straps %h enable %b", w, e);
  endtask : run
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    logic [31:0] w;
    w = $urandom(32'h47b2);
    run($urandom, 1'b1);
    for (int i = 0; i < 12; i++)
    begin
      w = $urandom;
      if (i < 4)
        w[26:16] = {i[0], i[1:0], i[1:0], i[0], i[1:0], 1'b0, {2{i[0]}}};
      run(w, i > 5 && $urandom_range(3) == 0);
    end
    apb(1'b0, 12'hffc, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    finish_test();
  end
  initial
  begin
    #100us;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : rsc_strap_capture_tb_top
bind rsc_strap_capture rsc_strap_capture_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .CLOCK, .NRST, .STRAP_CONFIG_ENABLE_N, .DATA_PINS, .RESET_OUT_N, .CONFIG_VALID,
  .MASTER_MODE, .MODE_RESERVED, .BOOT_PORT_WIDTH, .CLOCK_MODE, .CHIP_SELECT_EN,
  .PREADY, .PSLVERR);
`default_nettype wire
